// ==== fps_sequencer.v ====
// fps_sequencer.v: flash program/erase control and array interlocks
// assumes software runs from non-flash memory and keeps step delays
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.vh"
module fps_sequencer
(
    input wire mclk,
    input wire nrst,
    input wire clk_en,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire test_high_voltage,
    input wire wait_entry,
    input wire stop_entry,
    input wire monitor_secure_fail,
    input wire [7:0] protect_boundary_bits,
    output reg array_latch,
    output reg [15:0] array_addr,
    output reg [7:0] array_data,
    output reg array_program,
    output reg array_page_clear,
    output reg array_whole_clear,
    output reg array_high_voltage,
    output wire array_standby,
    output wire [7:0] read_data_out
);
    // ----------------------------------------
    // state and registers
    // ----------------------------------------
    // one-hot sequence states
    localparam [3:0] st_idle = 4'b0001;
    localparam [3:0] st_armed = 4'b0010;
    localparam [3:0] st_latched = 4'b0100;
    localparam [3:0] st_active = 4'b1000;
    // setup count kept as a 32-bit constant and cut to the counter width on purpose
    localparam [31:0] setup_load = `FPS_SETUP_CYC;
    reg [3:0] state;
    reg [3:0] next_state;
    reg write_op_select;
    reg clear_op_select;
    reg whole_array_select;
    reg high_voltage_on;
    reg protect_read;
    reg [15:0] staged_addr;
    reg [7:0] staged_data;
    reg [15:0] target_addr;
    reg [13:0] setup_cnt;
    reg refused;
    wire test_hv_s;
    wire wait_s;
    wire stop_s;
    wire secure_fail_s;
    wire hit;
    wire low_power;
    wire ctrl_wr;
    wire arr_wr;
    wire want_hv;
    wire sel_ok;
    wire hv_ok;
    wire [7:0] wd_ctrl;
    wire [15:0] wr_target;
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // two-cycle lag on every pin; a test voltage must stand before the voltage write
    fps_sync u_sync_tv (.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .din(test_high_voltage), .dout(test_hv_s));
    fps_sync u_sync_wt (.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .din(wait_entry), .dout(wait_s));
    fps_sync u_sync_sp (.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .din(stop_entry), .dout(stop_s));
    fps_sync u_sync_sf (.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .din(monitor_secure_fail),
        .dout(secure_fail_s));
    // ----------------------------------------
    // protection check on the latched target
    // ----------------------------------------
    fps_guard u_guard
    (
        .protect_boundary_bits(protect_boundary_bits),
        .addr(target_addr),
        .whole(clear_op_select && whole_array_select),
        .test_high_voltage(test_hv_s),
        .protected_hit(hit)
    );
    // ----------------------------------------
    // decode
    // ----------------------------------------
    // wait and stop share one abort path
    assign low_power = wait_s || stop_s;
    // register strobes only count on enabled edges
    assign ctrl_wr = clk_en && reg_wr && reg_addr == `FPS_OFS_CONTROL;
    assign arr_wr = clk_en && reg_wr && reg_addr == `FPS_OFS_ARRAY_WR;
    assign wd_ctrl = reg_wdata;
    assign wr_target = staged_addr;
    // only the voltage bit of the written byte asks for high voltage
    assign want_hv = wd_ctrl[`FPS_BIT_HV_ON];
    // a select may rise only while the other is low; otherwise the pair is kept whole
    assign sel_ok = !(wd_ctrl[`FPS_BIT_WRITE_OP] && wd_ctrl[`FPS_BIT_CLEAR_OP]) &&
        !(wd_ctrl[`FPS_BIT_WRITE_OP] && clear_op_select) &&
        !(wd_ctrl[`FPS_BIT_CLEAR_OP] && write_op_select);
    // voltage needs a select, protect read, latched target, setup elapsed, no hit
    assign hv_ok = (write_op_select || clear_op_select) && protect_read &&
        state == st_latched && setup_cnt == 14'h0000 && !hit;
    // standby whenever no operation is selected and the voltage bit is low
    assign array_standby = !(write_op_select || clear_op_select || high_voltage_on);
    // standby returns the erased ones; outside standby the output is driven to zero
    assign read_data_out = array_standby ? `FPS_ERASED_BYTE : 8'h00;
    // ----------------------------------------
    // sequence state
    // ----------------------------------------
    always @*
    begin
        next_state = state;
        case (state)
            st_idle:
                if (write_op_select || clear_op_select)
                    next_state = st_armed;
            st_armed:
                if (arr_wr && protect_read)
                    next_state = st_latched;
            st_latched:
                if (high_voltage_on)
                    next_state = st_active;
            st_active:
                if (!high_voltage_on)
                    next_state = st_idle;
            default:
                next_state = st_idle;
        endcase
        if (!(write_op_select || clear_op_select || high_voltage_on))
            next_state = st_idle;
    end
    // control bits, targets and counters
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= st_idle;
            write_op_select <= 1'b0;
            clear_op_select <= 1'b0;
            whole_array_select <= 1'b0;
            high_voltage_on <= 1'b0;
            protect_read <= 1'b0;
            target_addr <= 16'h0000;
            setup_cnt <= 14'h0000;
            refused <= 1'b0;
        end
        else if (clk_en)
        begin
            if (low_power && !array_standby)
            begin
                // abort: every select and the voltage drop together
                // low power wins over a register write in the same cycle
                state <= st_idle;
                write_op_select <= 1'b0;
                clear_op_select <= 1'b0;
                whole_array_select <= 1'b0;
                high_voltage_on <= 1'b0;
                protect_read <= 1'b0;
            end
            else
            begin
                state <= next_state;
                if (ctrl_wr)
                begin
                    // a refused pair leaves both selects as they were
                    if (sel_ok)
                    begin
                        write_op_select <= wd_ctrl[`FPS_BIT_WRITE_OP];
                        clear_op_select <= wd_ctrl[`FPS_BIT_CLEAR_OP];
                    end
                    whole_array_select <= wd_ctrl[`FPS_BIT_WHOLE];
                    // refused voltage leaves the bit low
                    high_voltage_on <= want_hv && (high_voltage_on || hv_ok);
                    refused <= want_hv && !high_voltage_on && !hv_ok;
                    if (!wd_ctrl[`FPS_BIT_WRITE_OP] && !wd_ctrl[`FPS_BIT_CLEAR_OP])
                        protect_read <= 1'b0;
                end
                if (clk_en && reg_rd && reg_addr == `FPS_OFS_PROTECT && (write_op_select || clear_op_select))
                    protect_read <= 1'b1;
                if (arr_wr && state == st_armed && protect_read)
                begin
                    // secured monitor erase aims at the protect byte
                    target_addr <= (secure_fail_s && whole_array_select) ? `FPS_PROTECT_ADDR : wr_target;
                    setup_cnt <= setup_load[13:0];
                end
                // counter runs down once per enabled edge and parks at zero
                else if (setup_cnt != 14'h0000)
                    setup_cnt <= setup_cnt - 14'h0001;
            end
        end
    end
    // ----------------------------------------
    // staged target and byte
    // ----------------------------------------
    // software stages address and data first; the array write commits them later
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            staged_addr <= 16'h0000;
            staged_data <= 8'h00;
        end
        else if (clk_en && reg_wr)
        begin
            case (reg_addr)
                `FPS_OFS_ADDR_LO: staged_addr[7:0] <= reg_wdata;
                `FPS_OFS_ADDR_HI: staged_addr[15:8] <= reg_wdata;
                `FPS_OFS_DATA: staged_data <= reg_wdata;
                default: staged_data <= staged_data;
            endcase
        end
    end
    // ----------------------------------------
    // array strobes
    // ----------------------------------------
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            array_latch <= 1'b0;
            array_addr <= 16'h0000;
            array_data <= 8'h00;
            array_program <= 1'b0;
            array_page_clear <= 1'b0;
            array_whole_clear <= 1'b0;
            array_high_voltage <= 1'b0;
        end
        else if (clk_en)
        begin
            // row programming latches byte and address while selected
            // only under voltage, so the row-select write never counts as a data byte
            array_latch <= arr_wr && write_op_select && high_voltage_on && !low_power && !hit &&
                (wr_target & `FPS_ROW_MASK) == (target_addr & `FPS_ROW_MASK);
            if (arr_wr && write_op_select)
            begin
                array_addr <= wr_target;
                array_data <= staged_data;
            end
            else if (state == st_latched && clear_op_select)
                array_addr <= target_addr & `FPS_PAGE_MASK;
            // strobes fall on the first edge that sees low power, the same edge as the abort
            array_program <= write_op_select && high_voltage_on && !low_power;
            array_page_clear <= clear_op_select && !whole_array_select && high_voltage_on && !low_power;
            array_whole_clear <= clear_op_select && whole_array_select && high_voltage_on && !low_power;
            array_high_voltage <= high_voltage_on && !low_power;
        end
    end
    // ----------------------------------------
    // register read port, data one cycle later
    // ----------------------------------------
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (clk_en)
        begin
            reg_rdata <= 8'h00;
            if (reg_rd)
            begin
                case (reg_addr)
                    `FPS_OFS_CONTROL: reg_rdata <= {4'h0, high_voltage_on, whole_array_select,
                        clear_op_select, write_op_select};
                    `FPS_OFS_PROTECT: reg_rdata <= protect_boundary_bits;
                    // status exposes the one-hot state for bring-up
                    `FPS_OFS_STATUS: reg_rdata <= {2'b00, refused, hit, state};
                    `FPS_OFS_DATA: reg_rdata <= staged_data;
                    `FPS_OFS_ADDR_LO: reg_rdata <= staged_addr[7:0];
                    `FPS_OFS_ADDR_HI: reg_rdata <= staged_addr[15:8];
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== fps_defs.vh ====
// fps_defs.vh: constants for the flash program/erase sequencer
// assumes inclusion by bare name from the design files
`ifndef FPS_DEFS_VH
`define FPS_DEFS_VH
// ----------------------------------------
// register offsets (plain register port)
// ----------------------------------------
`define FPS_OFS_CONTROL 4'h0
`define FPS_OFS_PROTECT 4'h1
`define FPS_OFS_STATUS 4'h2
`define FPS_OFS_DATA 4'h3
`define FPS_OFS_ADDR_LO 4'h4
`define FPS_OFS_ADDR_HI 4'h5
`define FPS_OFS_ARRAY_WR 4'h6
// ----------------------------------------
// control register fields
// ----------------------------------------
`define FPS_BIT_WRITE_OP 0
`define FPS_BIT_CLEAR_OP 1
`define FPS_BIT_WHOLE 2
`define FPS_BIT_HV_ON 3
`define FPS_CONTROL_RESET 8'h00
`define FPS_PROTECT_OPEN 8'hff
// ----------------------------------------
// memory layout
// ----------------------------------------
`define FPS_ARRAY_START 16'he000
`define FPS_PROTECT_ADDR 16'hff7e
`define FPS_PAGE_MASK 16'hffc0
`define FPS_ROW_MASK 16'hffe0
`define FPS_ERASED_BYTE 8'hff
// ----------------------------------------
// timing, ns and cycles at 4 ns clock
// ----------------------------------------
`define FPS_CLK_NS 4
`define FPS_SETUP_NS 10000
`define FPS_SETUP_CYC ((`FPS_SETUP_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`endif

// ==== fps_sync.v ====
// fps_sync.v: two-flop synchroniser for one level
// assumes asynchronous input and a single mclk domain
`timescale 1ns/1ps
`default_nettype none
module fps_sync
(
    input wire mclk,
    input wire nrst,
    input wire clk_en,
    input wire din,
    output reg dout
);
    reg meta;
    // first flop read only by the second
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta <= 1'b0;
            dout <= 1'b0;
        end
        else if (clk_en)
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== fps_guard.v ====
// fps_guard.v: protect-range check for one target address
// assumes protect byte and address stable in the same cycle
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.vh"
module fps_guard
(
    input wire [7:0] protect_boundary_bits,
    input wire [15:0] addr,
    input wire whole,
    input wire test_high_voltage,
    output wire protected_hit
);
    wire [15:0] start;
    wire locked;
    // boundary bits are address [13:6], top two ones, low six zeros
    assign start = {2'b11, protect_boundary_bits, 6'b000000};
    // all ones leaves the array open; any other value locks the register too
    assign locked = (protect_boundary_bits != `FPS_PROTECT_OPEN);
    // zero protects everything because start falls below the array
    assign protected_hit = locked && !test_high_voltage &&
        (whole || addr >= start || addr == `FPS_PROTECT_ADDR);
endmodule
`default_nettype wire

// ==== fps_sequencer_monitor.sv ====
// fps_sequencer_monitor.sv: port-level checks on the flash sequencer
// assumes one mclk domain with clk_en held high
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.vh"
module fps_sequencer_monitor
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic test_high_voltage,
    input wire logic wait_entry,
    input wire logic stop_entry,
    input wire logic [7:0] protect_boundary_bits,
    input wire logic array_latch,
    input wire logic array_program,
    input wire logic array_page_clear,
    input wire logic array_whole_clear,
    input wire logic array_high_voltage,
    input wire logic array_standby,
    input wire logic [7:0] read_data_out
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    logic [11:0] since_wr;
    // edges since the last array write; saturates so it never wraps back under the setup count
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            since_wr <= 12'h000;
        else if (reg_wr && reg_addr == `FPS_OFS_ARRAY_WR)
            since_wr <= 12'h001;
        else if (since_wr != 12'hfff)
            since_wr <= since_wr + 12'h001;
    end
    property p_sel_excl;
        !(array_program && (array_page_clear || array_whole_clear));
    endproperty
    a_sel_excl: assert property (p_sel_excl) else $error("program and clear both active");
    property p_clear_excl;
        !(array_page_clear && array_whole_clear);
    endproperty
    a_clear_excl: assert property (p_clear_excl) else $error("page and whole clear together");
    property p_hv_sel;
        $rose(array_high_voltage) |-> (array_program || array_page_clear || array_whole_clear);
    endproperty
    a_hv_sel: assert property (p_hv_sel) else $error("voltage on without a select");
    property p_hv_setup;
        $rose(array_high_voltage) |-> since_wr >= `FPS_SETUP_CYC;
    endproperty
    a_hv_setup: assert property (p_hv_setup) else $error("voltage on before setup delay");
    property p_latch_prog;
        array_latch |-> array_program;
    endproperty
    a_latch_prog: assert property (p_latch_prog) else $error("byte latch outside program");
    property p_abort;
        (wait_entry || stop_entry) |-> ##[1:6] !(array_high_voltage || array_program
            || array_page_clear || array_whole_clear);
    endproperty
    a_abort: assert property (p_abort) else $error("wait or stop did not abort");
    property p_standby_read;
        array_standby |-> read_data_out == 8'hff;
    endproperty
    a_standby_read: assert property (p_standby_read) else $error("standby read not erased level");
    property p_standby_quiet;
        array_standby |=> !(array_high_voltage || array_program || array_page_clear || array_whole_clear);
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("array strobe active in standby");
    property p_locked_whole;
        $rose(array_high_voltage) && array_whole_clear && protect_boundary_bits != 8'hff |-> test_high_voltage;
    endproperty
    a_locked_whole: assert property (p_locked_whole) else $error("locked whole erase got voltage");
endmodule
bind fps_sequencer fps_sequencer_monitor mon (.mclk, .nrst, .reg_addr, .reg_wr, .test_high_voltage,
    .wait_entry, .stop_entry, .protect_boundary_bits, .array_latch, .array_program, .array_page_clear,
    .array_whole_clear, .array_high_voltage, .array_standby, .read_data_out);
`default_nettype wire

// ==== fps_array_model.sv ====
// fps_array_model.sv: one flash row and the stored protect byte
// assumes the testbench loads prot between operations
`timescale 1ns/1ps
`default_nettype none
module fps_array_model
(
    input wire logic mclk,
    input wire logic array_latch,
    input wire logic [15:0] array_addr,
    input wire logic [7:0] array_data,
    input wire logic array_program,
    input wire logic array_page_clear,
    input wire logic array_whole_clear,
    input wire logic array_high_voltage,
    output logic [7:0] protect_boundary_bits
);
    logic [7:0] prot = 8'hff;
    logic [7:0] mem [0:31];
    assign protect_boundary_bits = prot;
    initial foreach (mem[i]) mem[i] = 8'hff;
    // cells only change under voltage; programming can only pull bits to zero
    always @(posedge mclk)
    begin
        if (array_high_voltage && (array_page_clear || array_whole_clear))
            foreach (mem[i]) mem[i] <= 8'hff;
        else if (array_latch && array_program && array_high_voltage)
            mem[array_addr[4:0]] <= mem[array_addr[4:0]] & array_data;
    end
endmodule
`default_nettype wire

// ==== fps_sequencer_tb.sv ====
// fps_sequencer_tb.sv: register-level tests of the flash sequencer
// assumes the array model and the bound monitor
`timescale 1ns/1ps
`default_nettype none
`include "fps_defs.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module fps_sequencer_tb;
    logic mclk = 1'h0;
    logic nrst = 1'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'h0, reg_rd = 1'h0, test_high_voltage = 1'h0, wait_entry = 1'h0, stop_entry = 1'h0;
    logic monitor_secure_fail = 1'h0;
    logic [7:0] reg_rdata, array_data, read_data_out, protect_boundary_bits;
    logic [15:0] array_addr;
    logic array_latch, array_program, array_page_clear, array_whole_clear, array_high_voltage, array_standby;
    int mismatches = 0, total_checks = 0, cycles = 0;
    fps_sequencer dut (.mclk, .nrst, .clk_en(1'h1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .test_high_voltage, .wait_entry, .stop_entry, .monitor_secure_fail, .protect_boundary_bits,
        .array_latch, .array_addr, .array_data, .array_program, .array_page_clear, .array_whole_clear,
        .array_high_voltage, .array_standby, .read_data_out);
    fps_array_model core (.mclk, .array_latch, .array_addr, .array_data, .array_program, .array_page_clear,
        .array_whole_clear, .array_high_voltage, .protect_boundary_bits);
    initial forever #2 mclk = ~mclk;
    // a hang ends the run as a failure rather than running forever
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            mismatches++;
            end_of_test;
        end
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask
    // read data stand only in the cycle after the strobe, so sample just inside it
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    // the bench never runs code out of the modelled array
    // select, protect read, target, setup wait, then ask for voltage
    task run(input logic [7:0] sel, input logic [7:0] bits, input logic [15:0] a, input logic t, input logic ok);
        core.prot <= bits;
        test_high_voltage <= t;
        wr(`FPS_OFS_CONTROL, sel);
        rd(`FPS_OFS_PROTECT, bits);
        wr(`FPS_OFS_ADDR_LO, a[7:0]);
        wr(`FPS_OFS_ADDR_HI, a[15:8]);
        wr(`FPS_OFS_ARRAY_WR, 8'h00);
        repeat (2510) @(posedge mclk);
        wr(`FPS_OFS_CONTROL, sel | 8'h08);
        rd(`FPS_OFS_CONTROL, ok ? (sel | 8'h08) : sel);
        `CHK(array_high_voltage, ok)
    endtask
    // hold times are cut short here; the block does not time them itself
    task idle;
        wr(`FPS_OFS_CONTROL, 8'h08);
        repeat (4) @(posedge mclk);
        wr(`FPS_OFS_CONTROL, 8'h00);
        repeat (4) @(posedge mclk);
        test_high_voltage <= 1'h0;
        #1;
        `CHK(array_standby, 1'h1)
        $display("test step done at %0t", $time);
    endtask
    initial
    begin
        repeat (6) @(posedge mclk);
        nrst <= 1'h1;
        #1;
        `CHK(read_data_out, 8'hff)
        rd(`FPS_OFS_CONTROL, 8'h00);
        wr(`FPS_OFS_CONTROL, 8'h03);
        rd(`FPS_OFS_CONTROL, 8'h00);
        wr(`FPS_OFS_CONTROL, 8'h01);
        wr(`FPS_OFS_CONTROL, 8'h02);
        rd(`FPS_OFS_CONTROL, 8'h01);
        idle;
        run(8'h01, 8'h00, 16'he000, 1'h0, 1'h0);
        idle;
        run(8'h01, 8'hff, 16'he020, 1'h0, 1'h1);
        wr(`FPS_OFS_DATA, 8'ha5);
        wr(`FPS_OFS_ADDR_LO, 8'h21);
        wr(`FPS_OFS_ARRAY_WR, 8'ha5);
        repeat (7510) @(posedge mclk);
        `CHK(core.mem[1], 8'ha5)
        idle;
        run(8'h02, 8'h81, 16'he040, 1'h0, 1'h0);
        idle;
        run(8'h02, 8'h81, 16'he000, 1'h0, 1'h1);
        idle;
        run(8'h06, 8'h81, 16'he000, 1'h0, 1'h0);
        idle;
        run(8'h06, 8'h81, 16'he000, 1'h1, 1'h1);
        idle;
        // secured monitor whole erase is steered to the protect byte's page
        monitor_secure_fail <= 1'h1;
        run(8'h06, 8'hff, 16'he000, 1'h0, 1'h1);
        `CHK(array_addr, `FPS_PROTECT_ADDR & `FPS_PAGE_MASK)
        monitor_secure_fail <= 1'h0;
        idle;
        // voltage on, then wait or stop entry must drop everything
        for (int i = 0; i < 2; i++)
        begin
            run(8'h02, 8'hff, 16'he000, 1'h0, 1'h1);
            if (i == 0)
                wait_entry <= 1'h1;
            else
                stop_entry <= 1'h1;
            repeat (8) @(posedge mclk);
            #1;
            `CHK(array_high_voltage, 1'h0)
            rd(`FPS_OFS_CONTROL, 8'h00);
            wait_entry <= 1'h0;
            stop_entry <= 1'h0;
            idle;
        end
        end_of_test;
    end
endmodule
`default_nettype wire
